// file: mcu_decode.sv
`timescale 1ns/1ps
module mcu_decode (
    // command word
    input wire logic [15:0] code,
    // one-hot matches
    output logic is_storage,
    output logic is_lock,
    output logic is_sync,
    output logic is_cal,
    output logic is_cal_alt,
    output logic is_stop,
    output logic is_prog
);
    assign is_storage = (code == mcu_pkg::CODE_STORAGE);
    assign is_lock = (code == mcu_pkg::CODE_LOCK);
    assign is_sync = (code == mcu_pkg::CODE_SYNC);
    assign is_cal = (code == mcu_pkg::CODE_CAL);
    assign is_cal_alt = (code == mcu_pkg::CODE_CAL_ALT);
    assign is_stop = (code == mcu_pkg::CODE_STOP);
    assign is_prog = (code == mcu_pkg::CODE_PROG);
endmodule // mcu_decode

// file: mcu_ee_model.sv
`timescale 1ns/1ps
module mcu_ee_model (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // latency select
    input wire logic slow,
    // save handshake
    input wire logic ee_cal_wr_req,
    output logic ee_cal_wr_done
);
    logic [3:0] wait_r;

    // ----------------------------------------
    // eeprom save responder
    // ----------------------------------------
    // offsets written, then done pulse
    always_ff @(posedge clk)
    begin
        if (sys_rst || !ee_cal_wr_req || ee_cal_wr_done)
        begin
            wait_r <= slow ? 4'hb : 4'h2;
            ee_cal_wr_done <= 1'b0;
        end
        else if (wait_r == 4'h0)
            ee_cal_wr_done <= 1'b1;
        else
            wait_r <= wait_r - 4'h1;
    end
endmodule // mcu_ee_model

// file: mcu_main.sv
`timescale 1ns/1ps
// Behaviour
// (RQ1) ignore commands first second after reset
// (RQ2) storage command enters storage after delay
// (RQ3) host turns display off before storage
// (RQ4) storage command cleared within 900ms
// (RQ5) calibration during storage delay postpones storage
// (RQ6) lock command locks, clears register
// (RQ7) sync sets remaining charge from capacity
// (RQ8) calibration with sense inputs disconnected
// (RQ9) alternate calibration keeps sense inputs connected
// (RQ10) calibrating: blank display, only stop/lock
// (RQ11) calibration command cleared, started promptly
// (RQ12) calibration ends itself, saves offsets
// (RQ13) calibration capped at one hour
// (RQ14) stop aborts calibration, correction stays off
// (RQ15) correction enable cleared on start, set on success
// (RQ16) storage about 20s after calibration
// (RQ17) host locks before calibration completes
// (RQ18) program command bridges bus to eeprom
// (RQ19) battery address on bus ends bridge
// (RQ20) host waits 10ms before ending bridge
// (RQ21) alarm when charge below nonzero threshold
// (RQ22) threshold loaded from eeprom until written
// (RQ23) threshold unsigned 16 bit, unit selectable
// (RQ24) unit select picks 10mWh or mAh
// (RQ25) unknown command code has no effect
module mcu_main #(
    parameter longint IGNORE_CYC = mcu_pkg::IGNORE_CYC,
    parameter longint STORE_DLY_CYC = mcu_pkg::STORE_DLY_CYC,
    parameter longint CAL_MAX_CYC = mcu_pkg::CAL_MAX_CYC,
    parameter longint POST_CAL_CYC = mcu_pkg::POST_CAL_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register port from link layer
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_ack,
    // host bus address monitor
    input wire logic host_addr_valid,
    input wire logic [7:0] host_addr_byte,
    // eeprom side
    input wire logic ee_init_valid,
    input wire logic [7:0] ee_thr_lo,
    input wire logic [7:0] ee_thr_hi,
    output logic ee_cal_wr_req,
    input wire logic ee_cal_wr_done,
    output logic eeprom_bridge,
    output logic eeprom_power,
    // measurement side
    input wire logic cal_converged,
    input wire logic [15:0] full_charge_capacity,
    input wire logic [7:0] charge_end_percent,
    input wire logic [15:0] charge_left,
    input wire logic capacity_unit_select,
    output logic [15:0] remaining_charge,
    output logic remaining_charge_load,
    output logic cal_active,
    output logic sense_disconnect,
    output logic offset_correction_enable,
    output logic led_blank,
    output logic monitor_suspend,
    // status
    output logic sealed,
    output logic storage_enter,
    output logic low_capacity_flag,
    output logic report_unit_mwh
);
    // ----------------------------------------
    // register port
    // ----------------------------------------
    logic [15:0] cmd_r;
    logic pend_r;
    logic [15:0] thr_r;
    logic host_thr_r;
    logic [15:0] rdata_r;
    logic ack_r;
    logic wr_cmd;
    logic wr_thr;
    logic [15:0] rd_mux;

    assign wr_cmd = reg_wr && (reg_addr == mcu_pkg::IDX_CMD);
    assign wr_thr = reg_wr && (reg_addr == mcu_pkg::IDX_THR);
    assign rd_mux = (reg_addr == mcu_pkg::IDX_CMD) ? cmd_r :
                    (reg_addr == mcu_pkg::IDX_THR) ? thr_r : '0;
    assign reg_rdata = rdata_r;
    assign reg_ack = ack_r;

    // (RQ4) command register cleared after decode
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cmd_r <= mcu_pkg::CMD_RESET_VAL;
            pend_r <= 1'b0;
            rdata_r <= '0;
            ack_r <= 1'b0;
        end
        else
        begin
            cmd_r <= wr_cmd ? reg_wdata : mcu_pkg::CMD_RESET_VAL;
            pend_r <= wr_cmd;
            rdata_r <= reg_rd ? rd_mux : rdata_r;
            ack_r <= reg_wr || reg_rd;
        end
    end

    // (RQ22) eeprom load until host writes
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            thr_r <= mcu_pkg::THR_RESET_VAL;
            host_thr_r <= 1'b0;
        end
        else if (wr_thr)
        begin
            thr_r <= reg_wdata;
            host_thr_r <= 1'b1;
        end
        else if (ee_init_valid && !host_thr_r)
            thr_r <= {ee_thr_hi, ee_thr_lo};
    end

    // ----------------------------------------
    // decode and acceptance
    // ----------------------------------------
    logic dec_storage, dec_lock, dec_sync, dec_cal, dec_cal_alt, dec_stop, dec_prog;
    logic ign_done_r;
    logic ign_done_p;
    logic ign_start_r;
    logic sealed_r;
    logic bridge_r;
    mcu_pkg::mcu_cal_t cal_st;
    mcu_pkg::mcu_store_t stor_st;
    logic calibrating;
    logic accept;
    logic go_storage, go_lock, go_sync, go_cal, go_stop, go_prog;
    logic end_hit;

    mcu_decode u_dec (
        .code(cmd_r),
        .is_storage(dec_storage),
        .is_lock(dec_lock),
        .is_sync(dec_sync),
        .is_cal(dec_cal),
        .is_cal_alt(dec_cal_alt),
        .is_stop(dec_stop),
        .is_prog(dec_prog)
    );

    // (RQ1) one-second ignore window
    mcu_timer #(.W(mcu_pkg::TMR_W)) u_ign (
        .clk(clk),
        .sys_rst(sys_rst),
        .load(ign_start_r),
        .load_val(mcu_pkg::TMR_W'(IGNORE_CYC)),
        .clear(1'b0),
        .busy(),
        .done(ign_done_p)
    );

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ign_start_r <= 1'b1;
            ign_done_r <= 1'b0;
        end
        else
        begin
            ign_start_r <= 1'b0;
            ign_done_r <= ign_done_r || ign_done_p;
        end
    end

    assign calibrating = (cal_st != mcu_pkg::CAL_IDLE);
    // (RQ10) only stop and lock while calibrating
    assign accept = pend_r && ign_done_r && (!calibrating || dec_stop || dec_lock);
    // (RQ25) unmatched codes select nothing
    assign go_storage = accept && dec_storage && (stor_st == mcu_pkg::ST_IDLE);
    assign go_lock = accept && dec_lock;
    assign go_sync = accept && dec_sync;
    // (RQ8) (RQ9) calibration needs unlocked device
    assign go_cal = accept && (dec_cal || dec_cal_alt) && !sealed_r && !calibrating;
    assign go_stop = accept && dec_stop && (cal_st == mcu_pkg::CAL_RUN);
    // (RQ18) bridge only when unlocked
    assign go_prog = accept && dec_prog && !sealed_r && !bridge_r;
    // (RQ19) battery address, either direction bit
    assign end_hit = host_addr_valid && (host_addr_byte[7:1] == mcu_pkg::BATT_ADDR[7:1]);

    // ----------------------------------------
    // lock, bridge, sync, alarm
    // ----------------------------------------
    logic [23:0] sync_prod;
    logic [15:0] sync_val;
    logic [15:0] rc_r;
    logic rc_load_r;
    logic alarm_cond;
    logic low_cap_r;
    logic unit_r;

    // (RQ7) fraction of full capacity
    assign sync_prod = full_charge_capacity * charge_end_percent;
    assign sync_val = 16'(sync_prod / mcu_pkg::PCT_FULL);
    // (RQ21) (RQ23) unsigned compare, zero disables
    assign alarm_cond = (thr_r != mcu_pkg::THR_OFF) && (charge_left < thr_r);

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            sealed_r <= 1'b0;
            bridge_r <= 1'b0;
            rc_r <= '0;
            rc_load_r <= 1'b0;
            low_cap_r <= 1'b0;
            unit_r <= 1'b0;
        end
        else
        begin
            // (RQ6) lock is sticky
            sealed_r <= sealed_r || go_lock;
            bridge_r <= go_prog || (bridge_r && !end_hit);
            rc_r <= go_sync ? sync_val : rc_r;
            rc_load_r <= go_sync;
            low_cap_r <= alarm_cond;
            // (RQ24) capacity unit follows select
            unit_r <= capacity_unit_select;
        end
    end

    assign sealed = sealed_r;
    assign eeprom_bridge = bridge_r;
    assign eeprom_power = bridge_r;
    assign monitor_suspend = bridge_r;
    assign remaining_charge = rc_r;
    assign remaining_charge_load = rc_load_r;
    assign low_capacity_flag = low_cap_r;
    assign report_unit_mwh = unit_r;

    // ----------------------------------------
    // calibration
    // ----------------------------------------
    logic cal_tmr_done;
    logic oce_r;
    logic sense_r;
    logic cal_end;
    logic cal_ok;

    // (RQ13) one-hour cap
    mcu_timer #(.W(mcu_pkg::TMR_W)) u_cal (
        .clk(clk),
        .sys_rst(sys_rst),
        .load(go_cal),
        .load_val(mcu_pkg::TMR_W'(CAL_MAX_CYC)),
        .clear(go_stop),
        .busy(),
        .done(cal_tmr_done)
    );

    // (RQ12) ends on convergence or cap
    assign cal_end = (cal_st == mcu_pkg::CAL_RUN) && !go_stop && (cal_converged || cal_tmr_done);
    assign cal_ok = (cal_st == mcu_pkg::CAL_SAVE) && ee_cal_wr_done;

    // (RQ11) (RQ14) (RQ15) start, abort, completion
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cal_st <= mcu_pkg::CAL_IDLE;
            oce_r <= 1'b0;
            sense_r <= 1'b0;
        end
        else
        begin
            unique case (cal_st)
                mcu_pkg::CAL_IDLE:
                begin
                    if (go_cal)
                    begin
                        cal_st <= mcu_pkg::CAL_RUN;
                        oce_r <= 1'b0;
                        sense_r <= dec_cal;
                    end
                end
                mcu_pkg::CAL_RUN:
                begin
                    if (go_stop)
                        cal_st <= mcu_pkg::CAL_IDLE;
                    else if (cal_end)
                        cal_st <= mcu_pkg::CAL_SAVE;
                end
                mcu_pkg::CAL_SAVE:
                begin
                    if (ee_cal_wr_done)
                    begin
                        cal_st <= mcu_pkg::CAL_IDLE;
                        oce_r <= 1'b1;
                    end
                end
            endcase
            if (go_stop || cal_ok)
                sense_r <= 1'b0;
        end
    end

    assign cal_active = calibrating;
    assign led_blank = calibrating;
    assign sense_disconnect = sense_r;
    assign offset_correction_enable = oce_r;
    assign ee_cal_wr_req = (cal_st == mcu_pkg::CAL_SAVE);

    // ----------------------------------------
    // low-power storage
    // ----------------------------------------
    logic st_load;
    logic [mcu_pkg::TMR_W-1:0] st_val;
    logic st_clear;
    logic st_done;

    // (RQ2) (RQ5) (RQ16) delay, hold, post-calibration delay
    assign st_clear = (stor_st == mcu_pkg::ST_WAIT) && calibrating;
    assign st_load = go_storage ||
                     ((stor_st == mcu_pkg::ST_HOLD) && !calibrating);
    assign st_val = ((stor_st == mcu_pkg::ST_HOLD) && !calibrating && oce_r) ?
                    mcu_pkg::TMR_W'(POST_CAL_CYC) : mcu_pkg::TMR_W'(STORE_DLY_CYC);

    mcu_timer #(.W(mcu_pkg::TMR_W)) u_store (
        .clk(clk),
        .sys_rst(sys_rst),
        .load(st_load),
        .load_val(st_val),
        .clear(st_clear),
        .busy(),
        .done(st_done)
    );

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            stor_st <= mcu_pkg::ST_IDLE;
        else
        begin
            unique case (stor_st)
                mcu_pkg::ST_IDLE:
                    if (go_storage)
                        stor_st <= mcu_pkg::ST_WAIT;
                mcu_pkg::ST_WAIT:
                    if (calibrating)
                        stor_st <= mcu_pkg::ST_HOLD;
                    else if (st_done)
                        stor_st <= mcu_pkg::ST_SLEEP;
                mcu_pkg::ST_HOLD:
                    if (!calibrating)
                        stor_st <= oce_r ? mcu_pkg::ST_POST : mcu_pkg::ST_WAIT;
                mcu_pkg::ST_POST:
                    if (st_done)
                        stor_st <= mcu_pkg::ST_SLEEP;
                mcu_pkg::ST_SLEEP:
                    stor_st <= mcu_pkg::ST_SLEEP;
                default:
                    stor_st <= mcu_pkg::ST_IDLE;
            endcase
        end
    end

    assign storage_enter = (stor_st == mcu_pkg::ST_SLEEP);

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_cmd_cleared: assert property ((pend_r && !wr_cmd) |=> (cmd_r == '0)) // RQ4
        else $error("command register not cleared");
    a_ignore_window: assert property ((pend_r && !ign_done_r) |=> !calibrating && !$rose(sealed_r)) // RQ1
        else $error("command acted on inside ignore window");
    a_lock_set: assert property ((pend_r && ign_done_r && dec_lock) |=> sealed_r) // RQ6
        else $error("lock command not applied");
    a_cal_locked: assert property ((pend_r && sealed_r && dec_cal && !calibrating) |=> !calibrating) // RQ8
        else $error("calibration started while locked");
    a_cal_filter: assert property ((cal_st == mcu_pkg::CAL_RUN && pend_r && dec_prog) |=> $stable(bridge_r)) // RQ10
        else $error("command taken during calibration");
    a_cal_start: assert property (go_cal |=> (cal_st == mcu_pkg::CAL_RUN) && !oce_r && (sense_r == $past(dec_cal))) // RQ15
        else $error("calibration start wrong");
    a_stop_abort: assert property (go_stop |=> (cal_st == mcu_pkg::CAL_IDLE) && !oce_r ##1 !oce_r) // RQ14
        else $error("abort did not leave correction off");
    a_oce_success: assert property ($rose(oce_r) |-> $past(cal_st) == mcu_pkg::CAL_SAVE && $past(ee_cal_wr_done)) // RQ12
        else $error("correction enabled without save");
    a_bridge_end: assert property ((bridge_r && end_hit) |=> !bridge_r && !eeprom_power) // RQ19
        else $error("bridge not ended on battery address");
    a_sync_value: assert property (go_sync |=> rc_load_r && (rc_r == $past(sync_val))) // RQ7
        else $error("sync value wrong");
    a_alarm_flag: assert property (alarm_cond |=> low_cap_r && ($past(thr_r) != '0)) // RQ21
        else $error("low capacity flag not raised");
    a_storage_hold: assert property ((stor_st == mcu_pkg::ST_HOLD) |-> !storage_enter && $past(calibrating)) // RQ5
        else $error("storage entered during calibration");

    c_cal_done: cover property (cal_ok);
    c_storage_after_cal: cover property ((stor_st == mcu_pkg::ST_POST) ##1 storage_enter);
    c_bridge_end: cover property (bridge_r ##1 !bridge_r);
    c_abort: cover property (go_stop);
endmodule // mcu_main

// file: mcu_pkg.sv
package mcu_pkg;
    // ----------------------------------------
    // register map and field widths
    // ----------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam logic [7:0] IDX_CMD = 8'h00;
    localparam logic [7:0] IDX_THR = 8'h01;
    localparam logic [15:0] CMD_RESET_VAL = 16'h0000;
    localparam logic [15:0] THR_RESET_VAL = 16'h0000;

    // ----------------------------------------
    // maintenance command codes
    // ----------------------------------------
    localparam logic [15:0] CODE_STORAGE = 16'h0618;
    localparam logic [15:0] CODE_LOCK = 16'h062b;
    localparam logic [15:0] CODE_SYNC = 16'h064d;
    localparam logic [15:0] CODE_CAL = 16'h0653;
    localparam logic [15:0] CODE_CAL_ALT = 16'h067e;
    localparam logic [15:0] CODE_STOP = 16'h0660;
    localparam logic [15:0] CODE_PROG = 16'h0606;

    // host bus battery address, upper seven bits compared
    localparam logic [7:0] BATT_ADDR = 8'h16;
    localparam logic [23:0] PCT_FULL = 24'h000064;
    localparam logic [15:0] THR_OFF = 16'h0000;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam longint CLK_HZ = 100_000_000;
    localparam longint MS_PER_S = 1000;
    localparam longint S_PER_MIN = 60;
    localparam longint IGNORE_MS = 1000;
    localparam longint STORE_DLY_MS = 5000;
    localparam longint CLEAR_MAX_MS = 900;
    localparam longint CAL_START_MAX_MS = 3200;
    localparam longint STOP_MAX_MS = 20;
    localparam longint CAL_MAX_MIN = 60;
    localparam longint POST_CAL_S = 20;
    localparam longint BRIDGE_GAP_MS = 10;

    localparam longint IGNORE_CYC = IGNORE_MS * CLK_HZ / MS_PER_S;
    localparam longint STORE_DLY_CYC = (STORE_DLY_MS * CLK_HZ + MS_PER_S - 1) / MS_PER_S;
    localparam longint CAL_MAX_CYC = CAL_MAX_MIN * S_PER_MIN * CLK_HZ;
    localparam longint POST_CAL_CYC = POST_CAL_S * CLK_HZ;

    localparam int TMR_W = 42;

    // ----------------------------------------
    // state types
    // ----------------------------------------
    typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_SAVE} mcu_cal_t;
    typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_HOLD, ST_POST, ST_SLEEP} mcu_store_t;
endpackage

// file: mcu_timer.sv
`timescale 1ns/1ps
module mcu_timer #(
    parameter int W = 42
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // control
    input wire logic load,
    input wire logic [W-1:0] load_val,
    input wire logic clear,
    // status
    output logic busy,
    output logic done
);
    logic [W-1:0] cnt_r;
    logic busy_r;
    logic expire;

    assign expire = busy_r && (cnt_r <= W'(1));
    assign busy = busy_r;
    assign done = expire && !load && !clear;

    always_ff @(posedge clk)
    begin
        if (sys_rst || clear)
        begin
            cnt_r <= '0;
            busy_r <= 1'b0;
        end
        else if (load)
        begin
            cnt_r <= load_val;
            busy_r <= 1'b1;
        end
        else if (busy_r)
        begin
            cnt_r <= cnt_r - W'(1);
            busy_r <= !expire;
        end
    end
endmodule // mcu_timer

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk, sys_rst, reg_wr, reg_rd, host_addr_valid, ee_init_valid, ee_cal_wr_done;
    logic cal_converged, capacity_unit_select, slow, reg_ack, ee_cal_wr_req, eeprom_bridge;
    logic eeprom_power, remaining_charge_load, cal_active, sense_disconnect, led_blank;
    logic offset_correction_enable, monitor_suspend, sealed, storage_enter;
    logic low_capacity_flag, report_unit_mwh;
    logic [7:0] reg_addr, host_addr_byte, ee_thr_lo, ee_thr_hi, charge_end_percent;
    logic [15:0] reg_wdata, reg_rdata, full_charge_capacity, charge_left, remaining_charge;
    int mismatches = 0;
    int n_checks = 0;
    int cyc = 0;
    int k;
    localparam longint IGN = 20, STD = 30, CMX = 50, PCC = 40;

    mcu_main #(.IGNORE_CYC(IGN), .STORE_DLY_CYC(STD), .CAL_MAX_CYC(CMX), .POST_CAL_CYC(PCC))
    uut (.clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_ack,
        .host_addr_valid, .host_addr_byte, .ee_init_valid, .ee_thr_lo, .ee_thr_hi,
        .ee_cal_wr_req, .ee_cal_wr_done, .eeprom_bridge, .eeprom_power, .cal_converged,
        .full_charge_capacity, .charge_end_percent, .charge_left, .capacity_unit_select,
        .remaining_charge, .remaining_charge_load, .cal_active, .sense_disconnect,
        .offset_correction_enable, .led_blank, .monitor_suspend, .sealed, .storage_enter,
        .low_capacity_flag, .report_unit_mwh);
    mcu_ee_model ee (.clk, .sys_rst, .slow, .ee_cal_wr_req, .ee_cal_wr_done);

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
        chk(reg_ack, 16'h1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_ack, 16'h1);
        chk(reg_rdata, exp);
    endtask

    task automatic ee_load(input logic [15:0] v);
        @(posedge clk);
        ee_init_valid <= 1'b1;
        {ee_thr_hi, ee_thr_lo} <= v;
        @(posedge clk);
        ee_init_valid <= 1'b0;
    endtask

    task automatic haddr(input logic [7:0] b);
        @(posedge clk);
        host_addr_valid <= 1'b1;
        host_addr_byte <= b;
        @(posedge clk);
        host_addr_valid <= 1'b0;
        tick(2);
    endtask

    task automatic converge();
        @(posedge clk);
        cal_converged <= 1'b1;
        @(posedge clk);
        cal_converged <= 1'b0;
        for (k = 0; k < 40 && cal_active !== 1'b0; k++) tick(1);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_boot();
        rd(mcu_pkg::IDX_CMD, mcu_pkg::CMD_RESET_VAL);
        wr(mcu_pkg::IDX_CMD, mcu_pkg::CODE_LOCK);
        tick(2);
        chk(sealed, 16'h0);
        rd(mcu_pkg::IDX_CMD, 16'h0000);
        tick(int'(IGN));
    endtask

    task automatic t_thr();
        ee_load(16'h1234);
        rd(mcu_pkg::IDX_THR, 16'h1234);
        @(posedge clk);
        charge_left <= 16'h1233;
        tick(2);
        chk(low_capacity_flag, 16'h1);
        @(posedge clk);
        charge_left <= 16'h1234;
        tick(2);
        chk(low_capacity_flag, 16'h0);
        wr(mcu_pkg::IDX_THR, 16'hffff);
        ee_load(16'h0055);
        rd(mcu_pkg::IDX_THR, 16'hffff);
        chk(low_capacity_flag, 16'h1);
        wr(mcu_pkg::IDX_THR, mcu_pkg::THR_OFF);
        tick(2);
        chk(low_capacity_flag, 16'h0);
        wr(8'h07, 16'hbeef);
        rd(8'h07, 16'h0000);
        @(posedge clk);
        capacity_unit_select <= 1'b1;
        tick(2);
        chk(report_unit_mwh, 16'h1);
        @(posedge clk);
        capacity_unit_select <= 1'b0;
        tick(2);
        chk(report_unit_mwh, 16'h0);
    endtask

    task automatic t_sync();
        wr(mcu_pkg::IDX_CMD, 16'h0600);
        tick(2);
        chk({sealed, cal_active, eeprom_bridge, remaining_charge_load}, 16'h0);
        rd(mcu_pkg::IDX_CMD, 16'h0000);
        wr(mcu_pkg::IDX_CMD, mcu_pkg::CODE_SYNC);
        tick(1);
        chk(remaining_charge_load, 16'h1);
        chk(remaining_charge, 16'h0384);
        rd(mcu_pkg::IDX_CMD, 16'h0000);
    endtask

    task automatic t_prog();
        wr(mcu_pkg::IDX_CMD, mcu_pkg::CODE_PROG);
        tick(2);
        chk({eeprom_bridge, eeprom_power, monitor_suspend}, 16'h7);
        haddr(8'h12);
        chk(eeprom_bridge, 16'h1);
        // host gap after last eeprom write
        tick(10);
        haddr(mcu_pkg::BATT_ADDR);
        chk({eeprom_bridge, eeprom_power, monitor_suspend}, 16'h0);
    endtask

    task automatic t_cal_stop();
        wr(mcu_pkg::IDX_CMD, mcu_pkg::CODE_CAL);
        tick(2);
        chk({cal_active, sense_disconnect, led_blank}, 16'h7);
        chk(offset_correction_enable, 16'h0);
        rd(mcu_pkg::IDX_CMD, 16'h0000);
        wr(mcu_pkg::IDX_CMD, mcu_pkg::CODE_SYNC);
        tick(1);
        chk(remaining_charge_load, 16'h0);
        wr(mcu_pkg::IDX_CMD, mcu_pkg::CODE_PROG);
        tick(2);
        chk(eeprom_bridge, 16'h0);
        wr(mcu_pkg::IDX_CMD, mcu_pkg::CODE_STOP);
        tick(2);
        chk({cal_active, offset_correction_enable, led_blank}, 16'h0);
    endtask

    task automatic t_cal_ok();
        slow = 1'b1;
        wr(mcu_pkg::IDX_CMD, mcu_pkg::CODE_CAL_ALT);
        tick(2);
        chk({cal_active, sense_disconnect}, 16'h2);
        converge();
        chk({cal_active, offset_correction_enable}, 16'h1);
        slow = 1'b0;
        wr(mcu_pkg::IDX_CMD, mcu_pkg::CODE_CAL);
        for (k = 0; k < 80 && ee_cal_wr_req !== 1'b1; k++) tick(1);
        chk(16'(k > CMX - 8 && k < CMX + 4), 16'h1);
        for (k = 0; k < 40 && cal_active !== 1'b0; k++) tick(1);
        chk(offset_correction_enable, 16'h1);
    endtask

    task automatic t_ship();
        // host has the display off before storage
        wr(mcu_pkg::IDX_CMD, mcu_pkg::CODE_STORAGE);
        rd(mcu_pkg::IDX_CMD, 16'h0000);
        wr(mcu_pkg::IDX_CMD, mcu_pkg::CODE_CAL);
        tick(2);
        chk(cal_active, 16'h1);
        wr(mcu_pkg::IDX_CMD, mcu_pkg::CODE_LOCK);
        tick(2);
        chk(sealed, 16'h1);
        tick(int'(STD) + 5);
        chk(storage_enter, 16'h0);
        converge();
        chk(offset_correction_enable, 16'h1);
        tick(int'(PCC) - 8);
        chk(storage_enter, 16'h0);
        tick(16);
        chk(storage_enter, 16'h1);
        wr(mcu_pkg::IDX_CMD, mcu_pkg::CODE_PROG);
        tick(2);
        chk(eeprom_bridge, 16'h0);
    endtask

    // ----------------------------------------
    // clock, sequence, timeout
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        sys_rst = 1'b1;
        {reg_wr, reg_rd, host_addr_valid, ee_init_valid, cal_converged} = 5'h00;
        {capacity_unit_select, slow} = 2'h0;
        {reg_addr, host_addr_byte, ee_thr_lo, ee_thr_hi} = 32'h0000_0000;
        reg_wdata = 16'h0000;
        charge_left = 16'h0000;
        full_charge_capacity = 16'h03e8;
        charge_end_percent = 8'h5a;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        t_boot();
        t_thr();
        t_sync();
        t_prog();
        t_cal_stop();
        t_cal_ok();
        t_ship();
        close_out();
    end

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            mismatches++;
            close_out();
        end
    end
endmodule // tb_top
